// ---- src/agc_threshold_yc_delay_regs.sv ----
// Configuration bank for the AGC thresholds and the luma versus chroma delay, with their logic.
`timescale 1ns/1ps
`include "agc_defines.svh"

////////////////////////////////////////////////////////////////////////////////
module agc_threshold_yc_delay_regs (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst,
    // Register access from the control interface.
    input wire agc_pkg::agc_req_s req,
    output logic [7:0] rd_data,
    output logic rd_valid,
    // Video samples in, one per quarter subcarrier period, and field marker.
    input wire agc_pkg::agc_sample_s sample_in,
    input wire logic field_start,
    // Aligned samples out.
    output agc_pkg::agc_sample_s sample_out,
    // Gain control requests and current thresholds.
    output logic gain_dec,
    output logic gain_inc,
    output agc_pkg::agc_thresh_s thresh,
    output logic [6:0] sat_seen
);
    import agc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Threshold formulas, kept as functions since the low and saturation levels share one of them.
    function automatic logic [6:0] sat_count_of(input logic [7:0] r);
        sat_count_of = `AGC_SAT_CNT_BASE + {3'h0, r[`AGC_POINTS_LSB +: 2], 2'h0}
            + {1'h0, r[`AGC_LINES_LSB +: 2], 4'h0};
    endfunction : sat_count_of

    function automatic logic [9:0] level_of(input logic [9:0] base, input logic [1:0] f);
        level_of = base + {5'h00, f, 3'h0};
    endfunction : level_of

    ////////////////////////////////////////////////////////////////////////////
    // Register file.
    agc_byte_t rsvd_a_q, rsvd_a_d;
    agc_byte_t rsvd_b_q, rsvd_b_d;
    agc_byte_t delay_q, delay_d;
    agc_byte_t thr_q, thr_d;
    logic [7:0] rd_data_d;
    logic rd_valid_d;

    // Writes land on the next edge; reserved bits are stored as written so a
    // readback shows whether the host kept them at their required values.
    always_comb begin
        rsvd_a_d = rsvd_a_q;
        rsvd_b_d = rsvd_b_q;
        delay_d = delay_q;
        thr_d = thr_q;
        if (req.wr_en) begin
            case (req.addr)
                `AGC_OFS_RSVD_A: rsvd_a_d = req.wdata;
                `AGC_OFS_RSVD_B: rsvd_b_d = req.wdata;
                `AGC_OFS_DELAY: delay_d = req.wdata;
                `AGC_OFS_THRESH: thr_d = req.wdata;
                default: ;
            endcase
        end
    end

    // Reads answer one cycle later; unmapped offsets read as zero.
    always_comb begin
        rd_valid_d = req.rd_en;
        rd_data_d = 8'h00;
        if (req.rd_en) begin
            case (req.addr)
                `AGC_OFS_RSVD_A: rd_data_d = rsvd_a_q;
                `AGC_OFS_RSVD_B: rd_data_d = rsvd_b_q;
                `AGC_OFS_DELAY: rd_data_d = delay_q;
                `AGC_OFS_THRESH: rd_data_d = thr_q;
                default: rd_data_d = 8'h00;
            endcase
        end
    end

    // Register stage of the bank.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rsvd_a_q <= `AGC_RST_RSVD_A;
            rsvd_b_q <= `AGC_RST_RSVD_B;
            delay_q <= `AGC_RST_DELAY;
            thr_q <= `AGC_RST_THRESH;
            rd_data <= 8'h00;
            rd_valid <= 1'b0;
        end else begin
            rsvd_a_q <= rsvd_a_d;
            rsvd_b_q <= rsvd_b_d;
            delay_q <= delay_d;
            thr_q <= thr_d;
            rd_data <= rd_data_d;
            rd_valid <= rd_valid_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Luma versus chroma delay. Both paths keep a short history; the path that
    // must lag taps it, the other taps the newest entry so latency stays even.
    logic [9:0] luma_hist_q [0:`AGC_DELAY_DEPTH];
    logic [7:0] chroma_hist_q [0:`AGC_DELAY_DEPTH];
    logic signed [3:0] shift;
    logic [3:0] luma_tap, chroma_tap;
    agc_sample_s sample_d;

    // Negative codes make the luma lead, so the chroma is the one held back.
    always_comb begin
        shift = $signed(delay_q[`AGC_DELAY_MSB:`AGC_DELAY_LSB]);
        luma_tap = shift[3] ? 4'h0 : shift;
        chroma_tap = shift[3] ? 4'(-shift) : 4'h0;
        sample_d.valid = sample_in.valid;
        sample_d.luma = luma_hist_q[luma_tap];
        sample_d.chroma = chroma_hist_q[chroma_tap];
    end

    // History shifts only on valid samples, one quarter subcarrier apart.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int i = 0; i <= `AGC_DELAY_DEPTH; i++) begin
                luma_hist_q[i] <= 10'h000;
                chroma_hist_q[i] <= 8'h00;
            end
            sample_out <= '0;
        end else begin
            if (sample_in.valid) begin
                luma_hist_q[0] <= sample_in.luma;
                chroma_hist_q[0] <= sample_in.chroma;
                for (int i = 1; i <= `AGC_DELAY_DEPTH; i++) begin
                    luma_hist_q[i] <= luma_hist_q[i-1];
                    chroma_hist_q[i] <= chroma_hist_q[i-1];
                end
            end
            sample_out <= sample_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Gain control decisions.
    agc_thresh_s thr_now;
    logic [6:0] cnt_q, cnt_d;
    logic quiet_q, quiet_d;
    logic dec_d, inc_d, full_scale;

    // Counter saturates at its threshold so one field asks for one decrease
    // from counting; the level compare may ask again on any sample.
    always_comb begin
        thr_now.sat_count = sat_count_of(thr_q);
        thr_now.low_level = level_of(`AGC_LOW_BASE, thr_q[`AGC_LOW_LSB +: 2]);
        thr_now.sat_level = level_of(`AGC_LUMA_SAT_BASE, thr_q[`AGC_SAT_LSB +: 2]);
        full_scale = sample_in.valid && (sample_in.luma == `AGC_ADC_FULL_SCALE);
        cnt_d = cnt_q;
        quiet_d = quiet_q;
        dec_d = 1'b0;
        inc_d = 1'b0;
        if (field_start) begin
            inc_d = quiet_q;
            cnt_d = 7'h00;
            quiet_d = 1'b1;
        end
        if (sample_in.valid) begin
            if (sample_in.luma >= thr_now.low_level) begin
                quiet_d = 1'b0;
            end
            if (sample_in.luma > thr_now.sat_level) begin
                dec_d = 1'b1;
            end
            if (full_scale && (cnt_d < thr_now.sat_count)) begin
                cnt_d = cnt_d + 7'h01;
                if (cnt_d == thr_now.sat_count) begin
                    dec_d = 1'b1;
                end
            end
        end
        if (dec_d) begin
            inc_d = 1'b0;
        end
    end

    // Gain requests and state registers.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt_q <= 7'h00;
            quiet_q <= 1'b0;
            gain_dec <= 1'b0;
            gain_inc <= 1'b0;
            thresh <= '0;
            sat_seen <= 7'h00;
        end else begin
            cnt_q <= cnt_d;
            quiet_q <= quiet_d;
            gain_dec <= dec_d;
            gain_inc <= inc_d;
            thresh <= thr_now;
            sat_seen <= cnt_d;
        end
    end
endmodule : agc_threshold_yc_delay_regs

// ---- src/agc_defines.svh ----
// Offsets, reset values, field positions and threshold constants of the AGC/Y-C delay bank.
`ifndef AGC_DEFINES_SVH
`define AGC_DEFINES_SVH
`define AGC_OFS_RSVD_A 8'h13
`define AGC_OFS_RSVD_B 8'h14
`define AGC_OFS_DELAY 8'h15
`define AGC_OFS_THRESH 8'h16
`define AGC_RST_RSVD_A 8'h00
`define AGC_RST_RSVD_B 8'h00
`define AGC_RST_DELAY 8'h10
`define AGC_RST_THRESH 8'h7A
`define AGC_DELAY_LSB 0
`define AGC_DELAY_MSB 3
`define AGC_LINES_LSB 6
`define AGC_POINTS_LSB 4
`define AGC_LOW_LSB 2
`define AGC_SAT_LSB 0
`define AGC_SAT_CNT_BASE 7'h01
`define AGC_LOW_BASE 10'h304
`define AGC_LUMA_SAT_BASE 10'h327
`define AGC_ADC_FULL_SCALE 10'h3FF
`define AGC_DELAY_DEPTH 8
`endif

// ---- src/agc_pkg.sv ----
// Types shared by the AGC threshold and Y/C delay register bank.
package agc_pkg;
    typedef logic [7:0] agc_byte_t;

    // One video sample as it leaves the front end.
    typedef struct packed {
        logic valid;
        logic [9:0] luma;
        logic [7:0] chroma;
    } agc_sample_s;

    // Host write or read request to the configuration bank.
    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } agc_req_s;

    // Thresholds derived from the configuration.
    typedef struct packed {
        logic [6:0] sat_count;
        logic [9:0] low_level;
        logic [9:0] sat_level;
    } agc_thresh_s;
endpackage : agc_pkg

// ---- testbench/agc_host_model.sv ----
// Host controller model driving the register bank.
`timescale 1ns/1ps
module agc_host_model (
    // Clock and bus.
    input wire logic clk_sys,
    output agc_pkg::agc_req_s req,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid
);
    import agc_pkg::*;
    initial req = '0;
    // Write; reserved bits get their required values, released lines flip.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        if (a == 8'h13 || a == 8'h14) d = 8'h00;
        if (a == 8'h15) d = {4'h1, d[3:0]};
        @(posedge clk_sys);
        req <= '{1'h1, 1'h0, a, d};
        @(posedge clk_sys);
        req <= '{1'h0, 1'h0, ~a, ~d};
    endtask : wr
    // Read; the answer stands one cycle after the strobe.
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge clk_sys);
        req <= '{1'h0, 1'h1, a, 8'h00};
        @(posedge clk_sys);
        req <= '{1'h0, 1'h0, ~a, 8'hA5};
        #1;
        d = rd_data;
        v = rd_valid;
    endtask : rd
endmodule : agc_host_model

// ---- testbench/agc_bank_props.sv ----
// Port checker of the AGC bank.
`timescale 1ns/1ps
module agc_bank_props (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst,
    // Watched ports.
    input wire agc_pkg::agc_sample_s sample_in,
    input wire logic field_start,
    input wire agc_pkg::agc_sample_s sample_out,
    input wire logic gain_dec,
    input wire logic gain_inc,
    input wire agc_pkg::agc_thresh_s thresh,
    input wire logic [6:0] sat_seen
);
    import agc_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Thresholds are judged only after their first update past reset.
    chk_sat_grid: assert property (!$past(rst) |->
        thresh.sat_count[1:0] == 2'h1 && thresh.sat_count <= 7'h3D) else $error("sat grid");
    chk_low_grid: assert property (!$past(rst) |->
        thresh.low_level inside {10'h304, 10'h30C, 10'h314, 10'h31C}) else $error("low grid");
    chk_luma_grid: assert property (!$past(rst) |->
        thresh.sat_level inside {10'h327, 10'h32F, 10'h337, 10'h33F}) else $error("luma grid");
    chk_luma_over: assert property (
        sample_in.valid && sample_in.luma > thresh.sat_level |=> gain_dec) else $error("no dec");
    chk_count_hit: assert property (sample_in.valid && sample_in.luma == 10'h3FF
        && !field_start && sat_seen + 7'h01 == thresh.sat_count |=> gain_dec) else $error("hit");
    chk_field_clear: assert property (field_start |=> sat_seen <= 7'h01) else $error("clr");
    chk_inc_cause: assert property (
        gain_inc |-> $past(field_start) && !gain_dec) else $error("inc");
    chk_out_valid: assert property (!$past(rst) |->
        sample_out.valid == $past(sample_in.valid)) else $error("out valid");
    cov_inc: cover property (gain_inc);
    cov_dec: cover property (gain_dec);
    cov_full: cover property (sat_seen == thresh.sat_count);
endmodule : agc_bank_props
bind agc_threshold_yc_delay_regs agc_bank_props i_agc_bank_props (.clk_sys, .rst,
    .sample_in, .field_start, .sample_out, .gain_dec, .gain_inc, .thresh, .sat_seen);

// ---- testbench/tb_agc_threshold_yc_delay_regs.sv ----
// Testbench of the AGC threshold and luma/chroma delay bank.
`timescale 1ns/1ps
module tb_agc_threshold_yc_delay_regs;
    import agc_pkg::*;
    logic clk_sys, rst, field_start, gain_dec, gain_inc, rd_valid, v;
    logic [7:0] rd_data, d;
    logic [6:0] sat_seen;
    logic [3:0] dl [4] = '{4'h0, 4'h7, 4'h8, 4'hF};
    agc_req_s req;
    agc_sample_s sample_in, sample_out;
    agc_thresh_s thresh;
    int num_errors = 0, comparisons = 0;
    agc_threshold_yc_delay_regs i_agc_threshold_yc_delay_regs (.clk_sys, .rst, .req, .rd_data,
        .rd_valid, .sample_in, .field_start, .sample_out, .gain_dec, .gain_inc, .thresh, .sat_seen);
    agc_host_model host (.clk_sys, .req, .rd_data, .rd_valid);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, d, v);
        chk("rd_valid", 10'h001, {9'h000, v});
        chk("rd_data", {2'h0, e}, {2'h0, d});
    endtask : rchk
    // One sample slot; outputs of the previous slot settle 1 ns later.
    task automatic smp(input logic vl, input logic [9:0] y, input logic [7:0] c, input logic f);
        @(posedge clk_sys);
        sample_in <= '{vl, y, c};
        field_start <= f;
        #1;
    endtask : smp
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict
    // Free-running system clock.
    initial begin
        clk_sys = 1'h0;
        forever #50 clk_sys = ~clk_sys;
    end
    // Main sequence; thresholds stay fixed while samples flow.
    initial begin
        rst = 1'h1;
        sample_in = '0;
        field_start = 1'h0;
        repeat (6) @(posedge clk_sys);
        rst <= 1'h0;
        rchk(8'h13, 8'h00);
        rchk(8'h14, 8'h00);
        rchk(8'h15, 8'h10);
        rchk(8'h16, 8'h7A);
        rchk(8'h20, 8'h00);
        chk("sat_count", 10'h01D, {3'h0, thresh.sat_count});
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            d = {i[1:0], 2'h3 - i[1:0], i[1:0], 2'h3 - i[1:0]};
            host.wr(8'h16, d);
            rchk(8'h16, d);
            chk("sat_count", 10'(1 + 4 * (3 - i) + 16 * i), {3'h0, thresh.sat_count});
            chk("low_level", 10'(772 + 8 * i), thresh.low_level);
            chk("sat_level", 10'(807 + 8 * (3 - i)), thresh.sat_level);
        end
        $display("test thresholds done");
        host.wr(8'h16, 8'h1F);
        smp(1'h0, 10'h000, 8'h00, 1'h1);
        for (int k = 0; k < 6; k++) smp(1'h1, 10'h3FF, 8'h00, 1'h0);
        smp(1'h1, 10'h33F, 8'h00, 1'h0);
        chk("sat_seen", 10'h005, {3'h0, sat_seen});
        smp(1'h1, 10'h340, 8'h00, 1'h0);
        chk("gain_dec", 10'h000, {9'h000, gain_dec});
        smp(1'h0, 10'h000, 8'h00, 1'h0);
        chk("gain_dec", 10'h001, {9'h000, gain_dec});
        for (int j = 0; j < 2; j++) begin
            smp(1'h0, 10'h000, 8'h00, 1'h1);
            repeat (3) smp(1'h1, 10'(795 + j), 8'h00, 1'h0);
            smp(1'h0, 10'h000, 8'h00, 1'h1);
            smp(1'h0, 10'h000, 8'h00, 1'h0);
            chk("gain_inc", 10'(1 - j), {9'h000, gain_inc});
            chk("sat_seen", 10'h000, {3'h0, sat_seen});
        end
        $display("test gain done");
        foreach (dl[j]) begin
            host.wr(8'h15, {4'hF, dl[j]});
            rchk(8'h15, {4'h1, dl[j]});
            for (int k = 0; k < 16; k++) smp(1'h1, 10'(k), 8'(k), 1'h0);
            smp(1'h0, 10'h000, 8'h00, 1'h0);
            chk("luma_out", 10'(dl[j][3] ? 14 : 14 - dl[j]), sample_out.luma);
            chk("chroma_out", 10'(dl[j][3] ? dl[j] - 2 : 14), {2'h0, sample_out.chroma});
        end
        $display("test delay done");
        // Reserved writes are forced to zero by the host; unmapped writes must be ignored.
        host.wr(8'h13, 8'hFF);
        host.wr(8'h20, 8'h5A);
        rchk(8'h13, 8'h00);
        rchk(8'h20, 8'h00);
        // A reset in mid-run must bring back every default, including the written delay.
        @(posedge clk_sys);
        rst <= 1'h1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'h0;
        rchk(8'h15, 8'h10);
        rchk(8'h16, 8'h7A);
        chk("sat_count", 10'h01D, {3'h0, thresh.sat_count});
        chk("low_level", 10'h314, thresh.low_level);
        chk("sat_level", 10'h337, thresh.sat_level);
        chk("sat_seen", 10'h000, {3'h0, sat_seen});
        $display("test second reset done");
        give_verdict();
    end
endmodule : tb_agc_threshold_yc_delay_regs
